//--- core/mprs_top.v
/*
  Modem control pins, ring indicator status and read strobe qualification
  of an asynchronous serial communications element, with an Avalon-MM
  register slave for software.
  Assumes one 25 MHz clock; all pins are asynchronous and are synchronised
  here; the receiver threshold signal comes from same-clock logic.
*/
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mprs_regs_vh_regs.vh"

module mprs_top (
  input  wire        clock,
  input  wire        arst_n,
  // avalon-mm slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // host pin side
  input  wire        chip_select_zero,
  input  wire        chip_select_one,
  input  wire        chip_select_two_low_n,
  input  wire        read_strobe_low_active_n,
  input  wire        read_strobe_high_active,
  input  wire [2:0]  pin_addr,
  output wire [7:0]  pin_data_out,
  output wire        pin_data_oe,
  output wire        driver_disable,
  input  wire        master_reset,
  // modem side
  input  wire        ring_indicator,
  input  wire        rx_threshold_reached,
  input  wire        rx_clock_16x,
  output wire        rx_sample_tick,
  output wire        user_output_one_n,
  output wire        user_output_two_n,
  output wire        request_to_send_n,
  output wire        modem_status_irq
);

  // ======================================================
  // pin synchronisers
  wire [`MPRS_SYNC_W-1:0] pins_raw;
  reg  [`MPRS_SYNC_W-1:0] pins_s1_q;
  reg  [`MPRS_SYNC_W-1:0] pins_s2_q;
  reg                     ring_s3_q;
  reg                     rclk_s3_q;

  assign pins_raw = {rx_clock_16x,
                     master_reset,
                     ring_indicator,
                     pin_addr,
                     read_strobe_high_active,
                     read_strobe_low_active_n,
                     chip_select_two_low_n,
                     chip_select_one,
                     chip_select_zero};

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_s1_q <= {`MPRS_SYNC_W{1'b0}};
      pins_s2_q <= {`MPRS_SYNC_W{1'b0}};
      ring_s3_q <= 1'b0;
      rclk_s3_q <= 1'b0;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
      ring_s3_q <= pins_s2_q[`MPRS_SY_RING];
      rclk_s3_q <= pins_s2_q[`MPRS_SY_RCLK];
    end
  end

  wire       mrst_s;
  wire       ring_s;
  wire       ring_rise;
  wire [2:0] paddr_s;

  assign mrst_s    = pins_s2_q[`MPRS_SY_MRST];
  assign ring_s    = pins_s2_q[`MPRS_SY_RING];
  assign ring_rise = ring_s & ~ring_s3_q;
  assign paddr_s   = pins_s2_q[`MPRS_SY_ADDR+2:`MPRS_SY_ADDR];

  // ======================================================
  // receiver clock tick
  reg rx_tick_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= pins_s2_q[`MPRS_SY_RCLK] & ~rclk_s3_q;
    end
  end

  assign rx_sample_tick = rx_tick_q;

  // ======================================================
  // pin read qualification
  wire pin_sel;
  wire pin_rd_act;
  reg  pin_rd_act_q;
  wire pin_rd_start;

  assign pin_sel = pins_s2_q[`MPRS_SY_SELA] &
                   pins_s2_q[`MPRS_SY_SELB] &
                   ~pins_s2_q[`MPRS_SY_CS2N];
  assign pin_rd_act = pin_sel &
                      (~pins_s2_q[`MPRS_SY_RDN] |
                       pins_s2_q[`MPRS_SY_RDH]);
  assign pin_rd_start = pin_rd_act & ~pin_rd_act_q;

  // ======================================================
  // avalon handshake
  reg  ack_q;
  wire bus_req;
  wire bus_done;
  wire wr_ok;

  assign bus_req     = read | write;
  assign waitrequest = bus_req & ~ack_q;
  assign bus_done    = bus_req & ack_q;
  assign wr_ok       = write & bus_done & byteenable[0];

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // ======================================================
  // control and status registers
  reg  [`MPRS_MCTL_W-1:0] mctl_q;
  reg  [`MPRS_IER_W-1:0]  ier_q;
  reg                     rflag_q;
  reg                     rflag_d;
  wire                    msr_rd_bus;
  wire                    msr_rd_pin;
  wire                    loop_on;
  wire [7:0]              msr_val;

  assign msr_rd_bus = read & bus_done & (address == `MPRS_MSR_ADDR);
  assign msr_rd_pin = pin_rd_start & (paddr_s == `MPRS_PIN_MSR);
  assign loop_on    = mctl_q[`MPRS_MCTL_LOOP];

  always @* begin
    // set wins over the clear of a status read
    rflag_d = rflag_q;
    if (msr_rd_bus | msr_rd_pin) begin
      rflag_d = 1'b0;
    end
    if (ring_rise) begin
      rflag_d = 1'b1;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mctl_q  <= `MPRS_MCTL_RST;
      ier_q   <= `MPRS_IER_RST;
      rflag_q <= 1'b0;
    end else if (mrst_s) begin
      mctl_q  <= `MPRS_MCTL_RST;
      ier_q   <= `MPRS_IER_RST;
      rflag_q <= 1'b0;
    end else begin
      rflag_q <= rflag_d;
      if (wr_ok && address == `MPRS_MCTL_ADDR) begin
        mctl_q <= writedata[`MPRS_MCTL_W-1:0];
      end
      if (wr_ok && address == `MPRS_IER_ADDR) begin
        ier_q <= writedata[`MPRS_IER_W-1:0];
      end
    end
  end

  assign msr_val = {1'b0,
                    ring_s,
                    3'b000,
                    rflag_q,
                    2'b00};

  // ======================================================
  // register read mux
  function [7:0] bus_mux;
    input [4:0] a;
    input [`MPRS_MCTL_W-1:0] m;
    input [`MPRS_IER_W-1:0] e;
    input [7:0] s;
    begin
      case (a)
        `MPRS_IER_ADDR: bus_mux = {4'h0, e};
        `MPRS_MCTL_ADDR: bus_mux = {2'b00, m};
        `MPRS_MSR_ADDR: bus_mux = s;
        default:        bus_mux = 8'h00;
      endcase
    end
  endfunction

  function [7:0] pin_mux;
    input [2:0] a;
    input [`MPRS_MCTL_W-1:0] m;
    input [`MPRS_IER_W-1:0] e;
    input [7:0] s;
    begin
      case (a)
        `MPRS_PIN_IER: pin_mux = {4'h0, e};
        `MPRS_PIN_MCTL: pin_mux = {2'b00, m};
        `MPRS_PIN_MSR: pin_mux = s;
        default:       pin_mux = 8'h00;
      endcase
    end
  endfunction

  reg [7:0] rdata_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (read && !ack_q) begin
      rdata_q <= bus_mux(address, mctl_q, ier_q, msr_val);
    end
  end

  assign readdata = {24'h000000, rdata_q};

  // ======================================================
  // pin data bus and driver disable
  reg [7:0] pdata_q;
  reg       poe_q;
  reg       drv_dis_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_rd_act_q <= 1'b0;
      pdata_q      <= 8'h00;
      poe_q        <= 1'b0;
      drv_dis_q    <= 1'b1;
    end else begin
      pin_rd_act_q <= pin_rd_act;
      poe_q        <= pin_rd_act;
      drv_dis_q    <= ~pin_rd_act;
      if (pin_rd_start) begin
        pdata_q <= pin_mux(paddr_s, mctl_q, ier_q, msr_val);
      end
    end
  end

  assign pin_data_out   = pdata_q;
  assign pin_data_oe    = poe_q;
  assign driver_disable = drv_dis_q;

  // ======================================================
  // modem control outputs
  reg usr1_n_q;
  reg usr2_n_q;
  reg rts_n_q;
  reg irq_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      usr1_n_q <= 1'b1;
      usr2_n_q <= 1'b1;
      rts_n_q  <= 1'b1;
      irq_q    <= 1'b0;
    end else if (mrst_s) begin
      usr1_n_q <= 1'b1;
      usr2_n_q <= 1'b1;
      rts_n_q  <= 1'b1;
      irq_q    <= 1'b0;
    end else begin
      usr1_n_q <= ~(mctl_q[`MPRS_MCTL_USR1] & ~loop_on);
      usr2_n_q <= ~(mctl_q[`MPRS_MCTL_USR2] & ~loop_on);
      rts_n_q  <= ~(mctl_q[`MPRS_MCTL_RTS] & ~loop_on &
                    ~(mctl_q[`MPRS_MCTL_AUTO] &
                      rx_threshold_reached));
      irq_q    <= rflag_d & ier_q[`MPRS_IER_MSI];
    end
  end

  assign user_output_one_n = usr1_n_q;
  assign user_output_two_n = usr2_n_q;
  assign request_to_send_n = rts_n_q;
  assign modem_status_irq  = irq_q;

endmodule // mprs_top
`default_nettype wire

//--- core/mprs_regs_vh_regs.vh
/*
  Offsets, field positions and reset values for the modem pin and read
  strobe block of the serial communications element.
  Assumes inclusion by bare name from core/ files.
*/
`ifndef MPRS_REGS_VH
`define MPRS_REGS_VH

// ========================================================
// bus byte addresses
`define MPRS_IER_ADDR   5'h04
`define MPRS_MCTL_ADDR  5'h10
`define MPRS_MSR_ADDR   5'h18

// ========================================================
// pin-side register indices
`define MPRS_PIN_IER    3'h1
`define MPRS_PIN_MCTL   3'h4
`define MPRS_PIN_MSR    3'h6

// ========================================================
// modem control fields
`define MPRS_MCTL_W     6
`define MPRS_MCTL_DTR   0
`define MPRS_MCTL_RTS   1
`define MPRS_MCTL_USR1  2
`define MPRS_MCTL_USR2  3
`define MPRS_MCTL_LOOP  4
`define MPRS_MCTL_AUTO  5
`define MPRS_MCTL_RST   6'h00

// ========================================================
// modem status fields
`define MPRS_MSR_RFLAG  2
`define MPRS_MSR_RING   6

// ========================================================
// interrupt enable fields
`define MPRS_IER_W      4
`define MPRS_IER_MSI    3
`define MPRS_IER_RST    4'h0

// ========================================================
// synchroniser layout
`define MPRS_SYNC_W     11
`define MPRS_SY_SELA    0
`define MPRS_SY_SELB    1
`define MPRS_SY_CS2N    2
`define MPRS_SY_RDN     3
`define MPRS_SY_RDH     4
`define MPRS_SY_ADDR    5
`define MPRS_SY_RING    8
`define MPRS_SY_MRST    9
`define MPRS_SY_RCLK    10

`endif

//--- tb/mprs_asserts.sv
/* port checker for mprs_top
   bound from tb; one clock, arst_n */
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module mprs_asserts (
  input wire clock,
  input wire arst_n,
  input wire write,
  input wire waitrequest,
  input wire chip_select_zero,
  input wire chip_select_one,
  input wire chip_select_two_low_n,
  input wire read_strobe_low_active_n,
  input wire read_strobe_high_active,
  input wire pin_data_oe,
  input wire driver_disable,
  input wire master_reset,
  input wire ring_indicator,
  input wire rx_sample_tick,
  input wire user_output_one_n,
  input wire user_output_two_n,
  input wire request_to_send_n,
  input wire modem_status_irq
);
  wire rd = !read_strobe_low_active_n || read_strobe_high_active;
  wire sel = chip_select_zero && chip_select_one && !chip_select_two_low_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_user1_fall: assert property (
    $fell(user_output_one_n) |-> $past(write && !waitrequest, 2))
    else $error("user output one fell without write");
  a_user2_fall: assert property (
    $fell(user_output_two_n) |-> $past(write && !waitrequest, 2))
    else $error("user output two fell without write");
  a_sel_read: assert property (
    (sel && rd)[*4] |-> pin_data_oe && !driver_disable)
    else $error("selected read not served");
  a_driver_disable_idle: assert property (
    (!rd)[*4] |-> driver_disable && !pin_data_oe)
    else $error("driver disable low without read");
  a_no_select: assert property (
    (!sel)[*4] |-> driver_disable)
    else $error("read served unselected");
  a_mr_outputs: assert property (
    master_reset[*4] |->
      user_output_one_n && user_output_two_n && request_to_send_n)
    else $error("outputs active in reset");
  a_irq_ring: assert property (
    $rose(modem_status_irq) |-> $past(ring_indicator, 2))
    else $error("irq without ring rise");
  a_tick_pulse: assert property (
    rx_sample_tick |=> !rx_sample_tick)
    else $error("tick longer than one cycle");
endmodule // mprs_asserts
`default_nettype wire

//--- tb/mprs_modem.sv
/* host strobe and modem pin model
   strobes and ring driven from tb at clock edges; rx_clock_16x toggles every 85 ns */
`timescale 1ns/1ps
`default_nettype none
// ==========
// far side
module mprs_modem (
  input wire clock,
  input wire ring_req,
  input wire rd_go,
  input wire use_high,
  output logic ring_indicator,
  output logic rx_clock_16x,
  output logic read_strobe_low_active_n,
  output logic read_strobe_high_active
);
  initial begin
    {ring_indicator, read_strobe_high_active} = 2'h0;
    read_strobe_low_active_n = 1'b1;
    rx_clock_16x = 1'b0;
    forever #85 rx_clock_16x = ~rx_clock_16x;
  end
  always @(posedge clock) begin
    ring_indicator <= ring_req;
    read_strobe_low_active_n <= !(rd_go && !use_high);
    read_strobe_high_active <= rd_go && use_high;
  end
endmodule // mprs_modem
`default_nettype wire

//--- tb/tb.sv
/* self-checking bench for mprs_top
   needs mprs_modem and mprs_asserts */
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module tb;
  logic clock, arst_n, read, write, waitrequest, master_reset;
  logic chip_select_zero, chip_select_one, chip_select_two_low_n;
  logic read_strobe_low_active_n, read_strobe_high_active;
  logic pin_data_oe, ring_indicator, rx_threshold_reached;
  logic rx_clock_16x, rx_sample_tick, user_output_one_n, driver_disable;
  logic user_output_two_n, request_to_send_n, modem_status_irq;
  logic ring_req, rd_go, use_high;
  logic [4:0] address;
  logic [2:0] pin_addr;
  logic [3:0] byteenable;
  logic [7:0] pin_data_out;
  logic [31:0] writedata, readdata, r;
  int fails, total_checks, mctl, i, v;
  int seed = 91;
  mprs_top dut (.*);
  mprs_modem u_mdm (.*);
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task chk_outs;
    chk("user1", user_output_one_n, !(mctl[2] && !mctl[4]));
    chk("user2", user_output_two_n, !(mctl[3] && !mctl[4]));
    chk("rts", request_to_send_n,
        !(mctl[1] && !mctl[4] && !(mctl[5] && rx_threshold_reached)));
  endtask
  task stop_test;
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #400000;
    fails++;
    stop_test;
  end
  initial begin
    {arst_n, read, write, master_reset, ring_req, rd_go} = 6'h00;
    {use_high, rx_threshold_reached, chip_select_zero} = 3'h0;
    {chip_select_one, chip_select_two_low_n} = 2'h1;
    {address, pin_addr, byteenable, writedata} = 44'h0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk_outs;
    for (i = 0; i < 24; i++) begin
      v = $random(seed);
      rx_threshold_reached <= v[8];
      byteenable <= {3'h0, v[9]};
      bus(1'b1, 5'h10, v);
      if (v[9]) mctl = v[5:0];
      @(posedge clock);
      chk_outs;
      bus(1'b0, 5'h10, 0);
      chk("mctl", r, mctl);
    end
    byteenable <= 4'h1;
    bus(1'b0, 5'h08, 0);
    chk("unmapped", r, 0);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 5'h04, i * 8);
      ring_req <= 1'b1;
      repeat (8) @(posedge clock);
      chk("irq", modem_status_irq, i);
      bus(1'b0, 5'h18, 0);
      chk("msr", r, 32'h44);
      bus(1'b0, 5'h18, 0);
      chk("msr", r, 32'h40);
      chk("irq", modem_status_irq, 0);
      ring_req <= 1'b0;
      repeat (8) @(posedge clock);
      bus(1'b0, 5'h18, 0);
      chk("msr", r, 0);
    end
    for (i = 0; i < 4; i++) begin
      chip_select_zero <= 1'b1;
      chip_select_one <= 1'b1;
      chip_select_two_low_n <= !i[1];
      pin_addr <= 3'h4;
      use_high <= i[0];
      rd_go <= 1'b1;
      repeat (6) @(posedge clock);
      chk("drv_dis", driver_disable, !i[1]);
      chk("oe", pin_data_oe, i[1]);
      if (i[1]) chk("pin", pin_data_out, mctl);
      rd_go <= 1'b0;
      repeat (6) @(posedge clock);
      chk("drv_dis", driver_disable, 1);
    end
    bus(1'b1, 5'h10, 32'h0e);
    master_reset <= 1'b1;
    repeat (5) @(posedge clock);
    master_reset <= 1'b0;
    mctl = 0;
    @(posedge clock);
    chk_outs;
    bus(1'b0, 5'h10, 0);
    chk("mctl", r, 0);
    stop_test;
  end
endmodule // tb
bind mprs_top mprs_asserts u_chk (.*);
`default_nettype wire
